// >>> logic/fxd_pkg.sv
// Shared types and constants of the floating-point exception class decoder
package fxd_pkg;

	// Register byte offsets
	localparam logic [7:0]  FXD_CTRL_OFS     = 8'h00;
	localparam logic [7:0]  FXD_STATUS_OFS   = 8'h04;
	localparam logic [7:0]  FXD_MASK_OFS     = 8'h08;
	localparam logic [7:0]  FXD_LAST_OFS     = 8'h0C;
	localparam logic [7:0]  FXD_COUNT_OFS    = 8'h10;
	localparam logic [23:0] FXD_UPPER_ZERO   = 24'h000000;

	// Reset values
	localparam logic [31:0] FXD_CTRL_RST     = 32'h00000001;
	localparam logic [5:0]  FXD_STATUS_RST   = 6'h00;
	localparam logic [5:0]  FXD_MASK_RST     = 6'h00;
	localparam logic [15:0] FXD_COUNT_RST    = 16'h0000;

	// Field positions
	localparam int          FXD_CTRL_EN_BIT  = 0;
	localparam int          FXD_LAST_OP_LSB  = 8;
	localparam int          FXD_LAST_FLG_LSB = 16;

	// Bus constants
	localparam int          FXD_LANES        = 4;
	localparam logic        FXD_HRESP_OKAY   = 1'h0;

	// Operation codes from the instruction decoder
	typedef enum logic [4:0] {
		FXD_OP_PACKED_DOUBLE_MULTIPLY       = 5'h00,
		FXD_OP_SCALAR_DOUBLE_MULTIPLY       = 5'h01,
		FXD_OP_PACKED_DOUBLE_SQUARE_ROOT    = 5'h02,
		FXD_OP_SCALAR_DOUBLE_SQUARE_ROOT    = 5'h03,
		FXD_OP_UNORDERED_SCALAR_COMPARE     = 5'h04,
		FXD_OP_MOVE_UPPER_DOUBLE            = 5'h05,
		FXD_OP_MOVE_LOWER_DOUBLE            = 5'h06,
		FXD_OP_MOVE_SCALAR_DOUBLE           = 5'h07,
		FXD_OP_MOVE_UNALIGNED_PACKED_DOUBLE = 5'h08,
		FXD_OP_EXTRACT_SIGN_BITS            = 5'h09,
		FXD_OP_INTERLEAVE_HIGH_HALVES       = 5'h0A,
		FXD_OP_INTERLEAVE_LOW_HALVES        = 5'h0B,
		FXD_OP_BITWISE_OR_PACKED            = 5'h0C,
		FXD_OP_BITWISE_XOR_PACKED           = 5'h0D,
		FXD_OP_SHUFFLE_PACKED_DOUBLE        = 5'h0E,
		FXD_OP_ALTERNATING_ADDSUB_DOUBLE    = 5'h0F,
		FXD_OP_ALTERNATING_ADDSUB_SINGLE    = 5'h10,
		FXD_OP_HORIZONTAL_ADD_DOUBLE        = 5'h11,
		FXD_OP_HORIZONTAL_ADD_SINGLE        = 5'h12,
		FXD_OP_HORIZONTAL_SUB_DOUBLE        = 5'h13,
		FXD_OP_HORIZONTAL_SUB_SINGLE        = 5'h14,
		FXD_OP_UNALIGNED_INTEGER_LOAD       = 5'h15,
		FXD_OP_DUPLICATE_DOUBLE_MOVE        = 5'h16,
		FXD_OP_DUPLICATE_HIGH_SINGLES_MOVE  = 5'h17,
		FXD_OP_DUPLICATE_LOW_SINGLES_MOVE   = 5'h18,
		FXD_OP_ROUND_PACKED_DOUBLE          = 5'h19,
		FXD_OP_ROUND_PACKED_SINGLE          = 5'h1A,
		FXD_OP_ROUND_SCALAR_DOUBLE          = 5'h1B,
		FXD_OP_ROUND_SCALAR_SINGLE          = 5'h1C,
		FXD_OP_INTEGER_GROUP                = 5'h1D
	} fxd_op_t;

	// Exception set, invalid in bit 0
	typedef struct packed {
		logic precision;
		logic underflow;
		logic overflow;
		logic divzero;
		logic denormal;
		logic invalid;
	} fxd_exc_t;

	// Integer status flags written by the unordered compare
	typedef struct packed {
		logic zf;
		logic pf;
		logic cf;
	} fxd_iflags_t;

	// Compare outcome from the datapath
	typedef struct packed {
		logic unordered;
		logic less;
		logic equal;
	} fxd_cmp_t;

	// Request from the instruction decoder
	typedef struct packed {
		logic    valid;
		fxd_op_t op;
		logic    suppress;
	} fxd_req_t;

	// Allowed exception sets
	localparam logic [5:0]  FXD_EXC_NONE     = 6'h00;
	localparam logic [5:0]  FXD_EXC_ARITH    = 6'h3B;
	localparam logic [5:0]  FXD_EXC_SQRT     = 6'h23;
	localparam logic [5:0]  FXD_EXC_CMP      = 6'h03;
	localparam logic [5:0]  FXD_EXC_ROUND    = 6'h21;
	localparam logic [5:0]  FXD_EXC_ROUND_SP = 6'h01;

	// Lane masks
	localparam logic [3:0]  FXD_LANE_NONE    = 4'h0;
	localparam logic [3:0]  FXD_LANE_SCALAR  = 4'h1;
	localparam logic [3:0]  FXD_LANE_DOUBLE  = 4'h3;
	localparam logic [3:0]  FXD_LANE_SINGLE  = 4'hF;

	// Integer flag patterns of the compare
	localparam logic [2:0]  FXD_FLG_UNORD    = 3'h7;
	localparam logic [2:0]  FXD_FLG_LESS     = 3'h1;
	localparam logic [2:0]  FXD_FLG_EQUAL    = 3'h4;
	localparam logic [2:0]  FXD_FLG_GREATER  = 3'h0;

endpackage

// >>> logic/fxd_class_table.sv
// Per-operation table of allowed exceptions and active lanes
`timescale 1ns/1ns
module fxd_class_table (
	// Operation in
	input  wire fxd_pkg::fxd_op_t  op,
	input  wire logic              suppress,
	// Classification out
	output fxd_pkg::fxd_exc_t      allowed,
	output logic [3:0]             lane_en,
	output logic                   is_compare
);
	import fxd_pkg::*;

	// Allowed set, lanes and compare flag in one word
	function automatic logic [10:0] classify(input fxd_op_t o, input logic sup);
		case (o)
			FXD_OP_PACKED_DOUBLE_MULTIPLY:      classify = {1'h0, FXD_LANE_DOUBLE, FXD_EXC_ARITH};
			FXD_OP_SCALAR_DOUBLE_MULTIPLY:      classify = {1'h0, FXD_LANE_SCALAR, FXD_EXC_ARITH};
			FXD_OP_PACKED_DOUBLE_SQUARE_ROOT:   classify = {1'h0, FXD_LANE_DOUBLE, FXD_EXC_SQRT};
			FXD_OP_SCALAR_DOUBLE_SQUARE_ROOT:   classify = {1'h0, FXD_LANE_SCALAR, FXD_EXC_SQRT};
			FXD_OP_UNORDERED_SCALAR_COMPARE:    classify = {1'h1, FXD_LANE_SCALAR, FXD_EXC_CMP};
			FXD_OP_ALTERNATING_ADDSUB_DOUBLE:   classify = {1'h0, FXD_LANE_DOUBLE, FXD_EXC_ARITH};
			FXD_OP_ALTERNATING_ADDSUB_SINGLE:   classify = {1'h0, FXD_LANE_SINGLE, FXD_EXC_ARITH};
			FXD_OP_HORIZONTAL_ADD_DOUBLE:       classify = {1'h0, FXD_LANE_DOUBLE, FXD_EXC_ARITH};
			FXD_OP_HORIZONTAL_SUB_DOUBLE:       classify = {1'h0, FXD_LANE_DOUBLE, FXD_EXC_ARITH};
			FXD_OP_HORIZONTAL_ADD_SINGLE:       classify = {1'h0, FXD_LANE_SINGLE, FXD_EXC_ARITH};
			FXD_OP_HORIZONTAL_SUB_SINGLE:       classify = {1'h0, FXD_LANE_SINGLE, FXD_EXC_ARITH};
			// rounding, precision only when not suppressed
			FXD_OP_ROUND_PACKED_DOUBLE:
				classify = {1'h0, FXD_LANE_DOUBLE, sup ? FXD_EXC_ROUND_SP : FXD_EXC_ROUND};
			FXD_OP_ROUND_PACKED_SINGLE:
				classify = {1'h0, FXD_LANE_SINGLE, sup ? FXD_EXC_ROUND_SP : FXD_EXC_ROUND};
			FXD_OP_ROUND_SCALAR_DOUBLE, FXD_OP_ROUND_SCALAR_SINGLE:
				classify = {1'h0, FXD_LANE_SCALAR, sup ? FXD_EXC_ROUND_SP : FXD_EXC_ROUND};
			// moves, logic and integer ops are quiet
			default:                            classify = {1'h0, FXD_LANE_NONE, FXD_EXC_NONE};
		endcase
	endfunction

	// Unpack the table word
	assign {is_compare, lane_en, allowed} = classify(op, suppress);

endmodule

// >>> logic/fxd_lane_merge.sv
// OR of per-lane detected exceptions over the active lanes
`timescale 1ns/1ns
module fxd_lane_merge #(
	parameter int LANES = fxd_pkg::FXD_LANES
) (
	// Lanes in
	input  wire fxd_pkg::fxd_exc_t [LANES-1:0] lane_exc,
	input  wire logic [LANES-1:0]              lane_en,
	// Merged set out
	output fxd_pkg::fxd_exc_t                  merged
);
	import fxd_pkg::*;

	fxd_exc_t [LANES-1:0] part;

	// chain of ORs over enabled lanes
	assign part[0] = lane_en[0] ? lane_exc[0] : fxd_exc_t'(FXD_EXC_NONE);
	genvar i;
	generate
		for (i = 1; i < LANES; i++) begin : g_lane
			assign part[i] = part[i-1] | (lane_en[i] ? lane_exc[i] : fxd_exc_t'(FXD_EXC_NONE));
		end
	endgenerate

	assign merged = part[LANES-1];

endmodule

// >>> logic/fxd_decoder.sv
// Floating-point exception class decoder with AHB-Lite registers
`timescale 1ns/1ns
module fxd_decoder #(
	parameter int LANES = fxd_pkg::FXD_LANES
) (
	// Clock, reset, enable
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	input  wire logic                          hce,
	// AHB-Lite slave
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic                               hreadyout,
	output logic                               hresp,
	output logic [31:0]                        hrdata,
	// Instruction decoder
	input  wire fxd_pkg::fxd_req_t             op_req,
	// Datapath detections
	input  wire fxd_pkg::fxd_exc_t [LANES-1:0] lane_exc,
	input  wire fxd_pkg::fxd_cmp_t             cmp_res,
	// Report to exception and status logic
	output logic                               rpt_valid,
	output fxd_pkg::fxd_exc_t                  rpt_set,
	output logic                               flags_we,
	output fxd_pkg::fxd_iflags_t               flags,
	// Interrupt
	output logic                               irq
);
	import fxd_pkg::*;

	fxd_exc_t    allowed;
	logic [3:0]  lane_en;
	logic        is_compare;
	fxd_exc_t    merged;
	fxd_exc_t    rpt_set_d;
	logic        go;
	logic        acc;
	logic        rd_acc;
	logic        wr_q;
	logic [7:0]  wr_ofs_q;
	logic [31:0] ctrl_q;
	logic [5:0]  status_q;
	logic [5:0]  mask_q;
	logic [31:0] ctrl_fwd;
	logic [5:0]  mask_fwd;
	logic [31:0] rd_word;
	logic [31:0] hrdata_q;
	logic        rpt_valid_q;
	fxd_exc_t    rpt_set_q;
	logic        flags_we_q;
	fxd_iflags_t flags_q;
	fxd_op_t     last_op_q;
	logic [15:0] count_q;
	logic        stat_clr;

	// Operation table
	fxd_class_table u_table (
		.op         (op_req.op),
		.suppress   (op_req.suppress),
		.allowed    (allowed),
		.lane_en    (lane_en),
		.is_compare (is_compare)
	);

	// Lane combiner, only lanes the operation really uses
	fxd_lane_merge #(
		.LANES (LANES)
	) u_merge (
		.lane_exc (lane_exc),
		.lane_en  (lane_en[LANES-1:0]),
		.merged   (merged)
	);

	// Flag pattern of a compare outcome; unordered takes priority
	function automatic fxd_iflags_t cmp_flags(input fxd_cmp_t c);
		if (c.unordered) begin
			cmp_flags = fxd_iflags_t'(FXD_FLG_UNORD);
		end else if (c.equal) begin
			cmp_flags = fxd_iflags_t'(FXD_FLG_EQUAL);
		end else if (c.less) begin
			cmp_flags = fxd_iflags_t'(FXD_FLG_LESS);
		end else begin
			cmp_flags = fxd_iflags_t'(FXD_FLG_GREATER);
		end
	endfunction

	// Reporting is gated by the enable bit; flags follow every compare
	assign go        = hce && op_req.valid && ctrl_q[FXD_CTRL_EN_BIT];
	// mask detections with the allowed set
	assign rpt_set_d = merged & allowed;

	// Report register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rpt_valid_q <= 1'h0;
			rpt_set_q   <= fxd_exc_t'(FXD_EXC_NONE);
			last_op_q   <= FXD_OP_INTEGER_GROUP;
		end else if (hce) begin
			rpt_valid_q <= go;
			if (go) begin
				rpt_set_q <= rpt_set_d;
				last_op_q <= op_req.op;
			end
		end
	end

	// integer flags from the compare result
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_we_q <= 1'h0;
			flags_q    <= fxd_iflags_t'(FXD_FLG_GREATER);
		end else if (hce) begin
			flags_we_q <= op_req.valid && is_compare;
			if (op_req.valid && is_compare) begin
				flags_q <= cmp_flags(cmp_res);
			end
		end
	end

	// Count of reported operations, wraps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= FXD_COUNT_RST;
		end else if (go) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// Bus accepts only when enabled, so a frozen block also stalls the bus
	assign hreadyout = hce;
	assign hresp     = FXD_HRESP_OKAY;
	assign acc       = hce && hsel && htrans[1] && hready;
	assign rd_acc    = acc && !hwrite;

	// Write data phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q     <= 1'h0;
			wr_ofs_q <= FXD_CTRL_OFS;
		end else if (hce) begin
			wr_q <= acc && hwrite;
			if (acc) begin
				wr_ofs_q <= haddr[7:0];
			end
		end
	end

	// Control and mask writes land in the write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= FXD_CTRL_RST;
			mask_q <= FXD_MASK_RST;
		end else if (hce && wr_q) begin
			if (wr_ofs_q == FXD_CTRL_OFS) begin
				ctrl_q <= {31'h00000000, hwdata[FXD_CTRL_EN_BIT]};
			end else if (wr_ofs_q == FXD_MASK_OFS) begin
				mask_q <= hwdata[5:0];
			end
		end
	end

	// Read of status clears it; a new event in the same cycle still sets
	assign stat_clr = rd_acc && (haddr[7:0] == FXD_STATUS_OFS) && (haddr[31:8] == FXD_UPPER_ZERO);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= FXD_STATUS_RST;
		end else if (hce) begin
			status_q <= (stat_clr ? FXD_STATUS_RST : status_q) | (go ? 6'(rpt_set_d) : FXD_EXC_NONE);
		end
	end

	// Forward a write still in its data phase so a following read is not stale
	assign ctrl_fwd = (wr_q && wr_ofs_q == FXD_CTRL_OFS) ? {31'h00000000, hwdata[FXD_CTRL_EN_BIT]} : ctrl_q;
	assign mask_fwd = (wr_q && wr_ofs_q == FXD_MASK_OFS) ? hwdata[5:0] : mask_q;

	// Read decode, unmapped reads as zero
	always_comb begin
		rd_word = 32'h00000000;
		if (haddr[31:8] != FXD_UPPER_ZERO) begin
			rd_word = 32'h00000000;
		end else if (haddr[7:0] == FXD_CTRL_OFS) begin
			rd_word = ctrl_fwd;
		end else if (haddr[7:0] == FXD_STATUS_OFS) begin
			rd_word = {26'h0000000, status_q};
		end else if (haddr[7:0] == FXD_MASK_OFS) begin
			rd_word = {26'h0000000, mask_fwd};
		end else if (haddr[7:0] == FXD_LAST_OFS) begin
			rd_word[5:0]                                = rpt_set_q;
			rd_word[FXD_LAST_OP_LSB +: 5]               = last_op_q;
			rd_word[FXD_LAST_FLG_LSB +: 3]              = flags_q;
		end else if (haddr[7:0] == FXD_COUNT_OFS) begin
			rd_word = {16'h0000, count_q};
		end
	end

	// Read data held in a register for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
		end else if (rd_acc) begin
			hrdata_q <= rd_word;
		end
	end

	// Outputs
	assign hrdata    = hrdata_q;
	assign rpt_valid = rpt_valid_q;
	assign rpt_set   = rpt_set_q;
	assign flags_we  = flags_we_q;
	assign flags     = flags_q;
	assign irq       = |(status_q & mask_q);

	mul_no_zdiv_a : assert property (@(posedge hclk) disable iff (!hresetn)
		(go && op_req.op == FXD_OP_PACKED_DOUBLE_MULTIPLY) |=> (rpt_valid_q && !rpt_set_q.divzero
		&& rpt_set_q.overflow == $past(lane_exc[0].overflow | lane_exc[1].overflow)))
		else $error("packed multiply report wrong");

	// scalar multiply takes lane zero only
	scalar_lane_a : assert property (@(posedge hclk) disable iff (!hresetn)
		(go && op_req.op == FXD_OP_SCALAR_DOUBLE_MULTIPLY) |=>
		(rpt_set_q.invalid == $past(lane_exc[0].invalid) && !rpt_set_q.divzero))
		else $error("scalar multiply report wrong");

	// square roots keep three bits clear
	sqrt_bits_a : assert property (@(posedge hclk) disable iff (!hresetn)
		(go && (op_req.op == FXD_OP_PACKED_DOUBLE_SQUARE_ROOT || op_req.op == FXD_OP_SCALAR_DOUBLE_SQUARE_ROOT))
		|=> (!rpt_set_q.divzero && !rpt_set_q.overflow && !rpt_set_q.underflow))
		else $error("square root raised forbidden bit");

	compare_flags_a : assert property (@(posedge hclk) disable iff (!hresetn)
		(hce && op_req.valid && op_req.op == FXD_OP_UNORDERED_SCALAR_COMPARE && cmp_res.unordered)
		|=> (flags_we_q && flags_q == fxd_iflags_t'(FXD_FLG_UNORD)
		&& (!rpt_valid_q || (rpt_set_q & ~FXD_EXC_CMP) == FXD_EXC_NONE)))
		else $error("compare flags wrong");

	moves_quiet_a : assert property (@(posedge hclk) disable iff (!hresetn)
		(go && (op_req.op == FXD_OP_MOVE_UPPER_DOUBLE || op_req.op == FXD_OP_MOVE_LOWER_DOUBLE
		|| op_req.op == FXD_OP_MOVE_SCALAR_DOUBLE || op_req.op == FXD_OP_MOVE_UNALIGNED_PACKED_DOUBLE))
		|=> (rpt_valid_q && rpt_set_q == FXD_EXC_NONE))
		else $error("move raised exception");

	// logic and shuffle ops are quiet
	logic_quiet_a : assert property (@(posedge hclk) disable iff (!hresetn)
		(go && op_req.op inside {FXD_OP_INTERLEAVE_HIGH_HALVES, FXD_OP_INTERLEAVE_LOW_HALVES,
		FXD_OP_BITWISE_OR_PACKED, FXD_OP_BITWISE_XOR_PACKED, FXD_OP_SHUFFLE_PACKED_DOUBLE,
		FXD_OP_EXTRACT_SIGN_BITS}) |=> (rpt_set_q == FXD_EXC_NONE))
		else $error("logic op raised exception");

	addsub_zdiv_a : assert property (@(posedge hclk) disable iff (!hresetn)
		(go && op_req.op inside {FXD_OP_ALTERNATING_ADDSUB_DOUBLE, FXD_OP_ALTERNATING_ADDSUB_SINGLE,
		FXD_OP_HORIZONTAL_ADD_DOUBLE, FXD_OP_HORIZONTAL_ADD_SINGLE, FXD_OP_HORIZONTAL_SUB_DOUBLE,
		FXD_OP_HORIZONTAL_SUB_SINGLE}) |=> (!rpt_set_q.divzero))
		else $error("add or subtract raised divide-by-zero");

	// duplicates, load and integer group quiet
	dup_int_quiet_a : assert property (@(posedge hclk) disable iff (!hresetn)
		(go && op_req.op inside {FXD_OP_DUPLICATE_DOUBLE_MOVE, FXD_OP_DUPLICATE_HIGH_SINGLES_MOVE,
		FXD_OP_DUPLICATE_LOW_SINGLES_MOVE, FXD_OP_UNALIGNED_INTEGER_LOAD, FXD_OP_INTEGER_GROUP})
		|=> (rpt_set_q == FXD_EXC_NONE))
		else $error("quiet op raised exception");

	round_bits_a : assert property (@(posedge hclk) disable iff (!hresetn)
		(go && op_req.op inside {FXD_OP_ROUND_PACKED_DOUBLE, FXD_OP_ROUND_PACKED_SINGLE,
		FXD_OP_ROUND_SCALAR_DOUBLE, FXD_OP_ROUND_SCALAR_SINGLE}) |=>
		((rpt_set_q & ~FXD_EXC_ROUND) == FXD_EXC_NONE
		&& rpt_set_q.precision == ($past(merged.precision) && !$past(op_req.suppress))))
		else $error("rounding report wrong");

	// the top single lane reaches the packed set
	single_or_a : assert property (@(posedge hclk) disable iff (!hresetn)
		(go && op_req.op == FXD_OP_HORIZONTAL_ADD_SINGLE && lane_exc[LANES-1].invalid)
		|=> rpt_set_q.invalid)
		else $error("lane not merged");

	// Status is sticky until read and drives the interrupt; a landing mask write may change it
	irq_level_a : assert property (@(posedge hclk) disable iff (!hresetn)
		(go && (rpt_set_d & mask_q) != FXD_EXC_NONE && !(wr_q && wr_ofs_q == FXD_MASK_OFS)) |=> irq)
		else $error("interrupt missing");

endmodule

// >>> tb/fxd_partner.sv
// Model of the instruction decoder and datapath that feed the decoder
`timescale 1ns/1ns
module fxd_partner (
	// Clock
	input  wire logic                 hclk,
	// Requests and detections out
	output fxd_pkg::fxd_req_t         op_req,
	output fxd_pkg::fxd_exc_t [3:0]   lane_exc,
	output fxd_pkg::fxd_cmp_t         cmp_res
);
	import fxd_pkg::*;

	// Quiet bus at time zero
	initial begin
		op_req = '0;
		lane_exc = '0;
		cmp_res = '0;
	end

	// One operation, valid for a single cycle; stale detections are inverted
	// so a design that samples late sees wrong data, not a lucky match
	// lane 0 lowest
	task automatic issue(input logic [4:0] op, input logic sup, input logic [23:0] lanes, input logic [2:0] cmp);
		@(posedge hclk);
		op_req <= '{valid: 1'b1, op: fxd_op_t'(op), suppress: sup};
		lane_exc <= lanes;
		cmp_res <= cmp;
		@(posedge hclk);
		op_req.valid <= 1'b0;
		lane_exc <= ~lanes;
		cmp_res <= ~cmp;
	endtask
endmodule

// >>> tb/tb_fxd_decoder.sv
// Self-checking bench of the exception class decoder
`timescale 1ns/1ns
module tb_fxd_decoder;
	import fxd_pkg::*;

	// Row: op code, suppress, lane detections, expected set
	typedef struct packed {
		logic [4:0]  op;
		logic        sup;
		logic [23:0] lanes;
		logic [5:0]  exp;
	} fxd_row_t;
	localparam logic [23:0] FULL = 24'hFFFFFF;
	localparam fxd_row_t ROWS [39] = '{
		'{5'h00,1'h0,FULL,6'h3B}, '{5'h01,1'h0,FULL,6'h3B}, '{5'h02,1'h0,FULL,6'h23}, '{5'h03,1'h0,FULL,6'h23},
		'{5'h04,1'h0,FULL,6'h03}, '{5'h05,1'h0,FULL,6'h00}, '{5'h06,1'h0,FULL,6'h00}, '{5'h07,1'h0,FULL,6'h00},
		'{5'h08,1'h0,FULL,6'h00}, '{5'h09,1'h0,FULL,6'h00}, '{5'h0A,1'h0,FULL,6'h00}, '{5'h0B,1'h0,FULL,6'h00},
		'{5'h0C,1'h0,FULL,6'h00}, '{5'h0D,1'h0,FULL,6'h00}, '{5'h0E,1'h0,FULL,6'h00}, '{5'h0F,1'h0,FULL,6'h3B},
		'{5'h10,1'h0,FULL,6'h3B}, '{5'h11,1'h0,FULL,6'h3B}, '{5'h12,1'h0,FULL,6'h3B}, '{5'h13,1'h0,FULL,6'h3B},
		'{5'h14,1'h0,FULL,6'h3B}, '{5'h15,1'h0,FULL,6'h00}, '{5'h16,1'h0,FULL,6'h00}, '{5'h17,1'h0,FULL,6'h00},
		'{5'h18,1'h0,FULL,6'h00}, '{5'h19,1'h0,FULL,6'h21}, '{5'h1A,1'h0,FULL,6'h21}, '{5'h1B,1'h0,FULL,6'h21},
		'{5'h1C,1'h0,FULL,6'h21}, '{5'h1D,1'h0,FULL,6'h00}, '{5'h19,1'h1,FULL,6'h01}, '{5'h1A,1'h1,FULL,6'h01},
		'{5'h1B,1'h1,FULL,6'h01}, '{5'h1C,1'h1,FULL,6'h01},
		'{5'h01,1'h0,24'hFFFFC0,6'h00}, '{5'h00,1'h0,24'hFFF040,6'h01}, '{5'h10,1'h0,24'h200000,6'h08},
		'{5'h0F,1'h0,24'hFFF000,6'h00}, '{5'h1C,1'h0,24'hFFFFC0,6'h00}
	};
	localparam logic [2:0] CMP_IN [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
	localparam logic [2:0] FLG_EXP [4] = '{FXD_FLG_UNORD, FXD_FLG_LESS, FXD_FLG_EQUAL, FXD_FLG_GREATER};

	logic                          hclk;
	logic                          hresetn;
	logic                          hce;
	logic                          hsel;
	logic [31:0]                   haddr;
	logic [1:0]                    htrans;
	logic                          hwrite;
	logic [2:0]                    hsize;
	logic [31:0]                   hwdata;
	logic                          hready;
	logic                          hresp;
	logic [31:0]                   hrdata;
	fxd_req_t                      op_req;
	fxd_exc_t [FXD_LANES-1:0]      lane_exc;
	fxd_cmp_t                      cmp_res;
	logic                          rpt_valid;
	fxd_exc_t                      rpt_set;
	logic                          flags_we;
	fxd_iflags_t                   flags;
	logic                          irq;
	logic [31:0]                   dummy;
	int                            err_total;
	int                            total_checks;

	// Device and its instruction-side partner
	fxd_decoder #(.LANES(FXD_LANES)) fxd_decoder_i (.hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .op_req(op_req), .lane_exc(lane_exc),
		.cmp_res(cmp_res), .rpt_valid(rpt_valid), .rpt_set(rpt_set), .flags_we(flags_we), .flags(flags),
		.irq(irq));
	fxd_partner fxd_partner_i (.hclk(hclk), .op_req(op_req), .lane_exc(lane_exc), .cmp_res(cmp_res));

	// Free-running 100 MHz clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask

	// Single word transfer; waits on hready in both phases, data taken at the last edge
	task automatic xfer(input logic [31:0] addr, input logic wr, input logic [31:0] wdata, output logic [31:0] rdata);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wdata;
		do @(posedge hclk); while (hready !== 1'b1);
		rdata = hrdata;
		#1;
	endtask

	// Write then read back to back, so the read meets the write still in its data phase
	task automatic wr_rd_chk(input logic [7:0] addr, input logic [31:0] wdata);
		logic [31:0] v;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, addr};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		do @(posedge hclk); while (hready !== 1'b1);
		hwrite <= 1'b0;
		hwdata <= wdata;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		do @(posedge hclk); while (hready !== 1'b1);
		v = hrdata;
		chk32(v, wdata);
		#1;
	endtask

	// Outputs that reset must leave at their idle values
	task automatic reset_chk();
		chk1(rpt_valid, 1'b0);
		chk1(flags_we, 1'b0);
		chk1(irq, 1'b0);
		chk1(hresp, FXD_HRESP_OKAY);
		chk32({26'h0, rpt_set}, 32'h0);
		chk32({29'h0, flags}, 32'h0);
	endtask

	task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] v;
		xfer({24'h0, addr}, 1'b0, 32'h0, v);
		chk32(v, exp);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Watchdog far beyond the couple of hundred cycles the tests need
	initial begin
		#200000;
		err_total++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		err_total = 0;
		total_checks = 0;
		hresetn = 1'b0;
		hce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (10) @(posedge hclk);
		reset_chk();
		hresetn <= 1'b1;
		rd_chk(FXD_CTRL_OFS, 32'h00000001);
		rd_chk(FXD_STATUS_OFS, 32'h0);
		rd_chk(FXD_MASK_OFS, 32'h0);
		rd_chk(FXD_COUNT_OFS, 32'h0);
		// Every op code with full detections, then lane-use cases
		foreach (ROWS[i]) begin
			fxd_partner_i.issue(ROWS[i].op, ROWS[i].sup, ROWS[i].lanes, 3'h0);
			#1;
			chk1(rpt_valid, 1'b1);
			chk32({26'h0, rpt_set}, {26'h0, ROWS[i].exp});
		end
		// Compare outcomes update integer flags
		for (int k = 0; k < 4; k++) begin
			fxd_partner_i.issue(5'h04, 1'b0, FULL, CMP_IN[k]);
			#1;
			chk1(flags_we, 1'b1);
			chk32({29'h0, flags}, {29'h0, FLG_EXP[k]});
		end
		rd_chk(FXD_STATUS_OFS, 32'h0000003B);
		rd_chk(FXD_STATUS_OFS, 32'h0);
		// Interrupt masked, unmasked, cleared by status read
		fxd_partner_i.issue(5'h0F, 1'b0, 24'h000001, 3'h0);
		#1;
		chk1(irq, 1'b0);
		xfer({24'h0, FXD_MASK_OFS}, 1'b1, 32'h00000001, dummy);
		chk1(irq, 1'b1);
		rd_chk(FXD_STATUS_OFS, 32'h00000001);
		chk1(irq, 1'b0);
		rd_chk(FXD_LAST_OFS, 32'h00000F01);
		// Disabled: no report, flags still written
		xfer({24'h0, FXD_CTRL_OFS}, 1'b1, 32'h0, dummy);
		fxd_partner_i.issue(5'h00, 1'b0, FULL, 3'h0);
		#1;
		chk1(rpt_valid, 1'b0);
		fxd_partner_i.issue(5'h04, 1'b0, FULL, 3'h1);
		#1;
		chk1(flags_we, 1'b1);
		chk32({29'h0, flags}, {29'h0, FXD_FLG_EQUAL});
		rd_chk(FXD_STATUS_OFS, 32'h0);
		rd_chk(FXD_COUNT_OFS, 32'h0000002C);
		xfer({24'h0, FXD_CTRL_OFS}, 1'b1, 32'h00000001, dummy);
		// Unmapped places read zero
		xfer(32'h00000014, 1'b1, 32'hFFFFFFFF, dummy);
		rd_chk(8'h14, 32'h0);
		xfer(32'h00000100, 1'b0, 32'h0, dummy);
		chk32(dummy, 32'h0);
		// Clock enable low stalls bus and ops
		hce <= 1'b0;
		fxd_partner_i.issue(5'h00, 1'b0, FULL, 3'h0);
		#1;
		chk1(rpt_valid, 1'b0);
		chk1(hready, 1'b0);
		hce <= 1'b1;
		// Forwarded mask read-back, then reset must clear it again
		wr_rd_chk(FXD_MASK_OFS, 32'h0000003F);
		// Reset in mid-run clears the counters
		@(posedge hclk);
		hresetn <= 1'b0;
		#1;
		reset_chk();
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(FXD_COUNT_OFS, 32'h0);
		rd_chk(FXD_MASK_OFS, 32'h0);
		rd_chk(FXD_CTRL_OFS, 32'h00000001);
		tally_and_finish();
	end
endmodule
